// >>> design/walk_cache_pkg.sv
// constants shared by the walk-cache control register block
package walk_cache_pkg;
  // register byte offsets on the wishbone bus
  localparam logic [15:0] WALK_CACHE_CONTROL_OFS     = 16'h8e00;
  localparam logic [15:0] NONSECURE_CONTROL_ZERO_OFS = 16'h8e20;
  localparam logic [15:0] SECURE_CONTROL_ZERO_OFS    = 16'h8e24;
  localparam logic [15:0] SECURE_SCOPE_CONTROL_OFS   = 16'h8e28;
  localparam logic [15:0] SECURE_INITIALISATION_OFS  = 16'h8e2c;

  // reset values
  localparam logic [31:0] WALK_CACHE_CONTROL_RST = 32'h0000_0000;
  localparam logic        CONTROL_BIT_RST        = 1'h0;

  // field positions
  localparam int CONTEXT_TAG_INDEXING_BIT    = 19;
  localparam int S2_LEVEL3_WALK_OFF_BIT      = 15;
  localparam int S2_LEVEL2_WALK_OFF_BIT      = 14;
  localparam int S1_LEVEL0_WALK_OFF_BIT      = 8;
  localparam int TRANSLATION_ENABLE_BIT      = 0;
  localparam int NONSECURE_TUNING_ACCESS_BIT = 0;
  localparam int INVALIDATE_EVERYTHING_BIT   = 0;
  localparam int INVALIDATE_PENDING_BIT      = 1;

  // walk-cache key widths
  localparam int VMID_W     = 16;
  localparam int ASID_W     = 16;
  localparam int VA_W       = 48;
  localparam int PAGE_SHIFT = 12;
  localparam int LEVEL_W    = 2;
endpackage

// >>> design/walk_cache_index.sv
// walk-cache index hash over vmid, optional asid and input address
`timescale 1ns/1ps
module walk_cache_index
  import walk_cache_pkg::*;
#(
  parameter int INDEX_W = 8
) (
  input  wire logic [VMID_W-1:0]  i_vmid,
  input  wire logic [ASID_W-1:0]  i_asid,
  input  wire logic [VA_W-1:0]    i_addr,
  input  wire logic               i_stage2,
  input  wire logic [LEVEL_W-1:0] i_level,
  input  wire logic               i_use_asid,
  output logic      [INDEX_W-1:0] o_index
);
  localparam int KEY_W = VMID_W + ASID_W + (VA_W - PAGE_SHIFT) + 1 + LEVEL_W;

  logic [KEY_W-1:0] key;

  // xor-fold the key down to the index width
  function automatic logic [INDEX_W-1:0] fold(input logic [KEY_W-1:0] k);
    logic [INDEX_W-1:0] r;
    r = '0;
    for (int i = 0; i < KEY_W; i++) begin
      r[i % INDEX_W] = r[i % INDEX_W] ^ k[i];
    end
    return fold_done(r);
  endfunction

  function automatic logic [INDEX_W-1:0] fold_done(input logic [INDEX_W-1:0] r);
    return r;
  endfunction

  // asid masked out while i_use_asid is clear, so entries differing only in asid collide
  always_comb begin
    key     = {i_vmid, (i_use_asid ? i_asid : {ASID_W{1'b0}}),
               i_addr[VA_W-1:PAGE_SHIFT], i_stage2, i_level}; // [R5] [R6]
    o_index = fold(key);
  end
endmodule

// >>> design/walk_cache_control.sv
// walk-cache control register with wishbone slave and lookup gating
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps
// What this block does
// R1: non-secure access reads zero and writes drop unless tuning access is granted.
// R2: register writes take effect only while both translation enables are zero.
// R3: software runs invalidate-everything after a change, before enabling translation.
// R4: software keeps auxiliary bits 31:20 and 18:16 at zero.
// R5: bit 19 picks indexing; scheme zero gives same index across asids.
// R6: asid scheme gives distinct indexes; asid-less invalidation scans whole cache.
// R7: bit 15 set stops use of stage 2 level 3 walk cache.
// R8: bit 14 clear keeps stage 2 level 2 walk cache in use.
// R9: every walk-cache level has its own disable bit.
// R10: bit 14 set disables stage 2 level 2 walk cache.
// R11: bits 13:12 and 11:8 disable s2 l1/l0 and s1 l3..l0 caches.
// R12: bit 19 zero means vmid-and-address indexing; reset gives that scheme.
// R13: a disabled level neither hits nor allocates; walks go to memory.
module walk_cache_control
  import walk_cache_pkg::*;
#(
  parameter int INDEX_W = 8
) (
  input  wire logic               i_sys_clk,
  input  wire logic               i_nrst,
  // classic wishbone slave
  input  wire logic               i_wb_cyc,
  input  wire logic               i_wb_stb,
  input  wire logic               i_wb_we,
  input  wire logic [15:0]        i_wb_adr,
  input  wire logic [3:0]         i_wb_sel,
  input  wire logic [31:0]        i_wb_dat,
  input  wire logic               i_wb_tga_ns,
  output logic      [31:0]        o_wb_dat,
  output logic                    o_wb_ack,
  // walk-cache lookup request
  input  wire logic               i_lk_valid,
  input  wire logic               i_lk_stage2,
  input  wire logic [LEVEL_W-1:0] i_lk_level,
  input  wire logic [VMID_W-1:0]  i_lk_vmid,
  input  wire logic [ASID_W-1:0]  i_lk_asid,
  input  wire logic [VA_W-1:0]    i_lk_addr,
  output logic                    o_lk_valid,
  output logic [INDEX_W-1:0]      o_lk_index,
  output logic                    o_lk_cache_use,
  // walk-cache invalidation request
  input  wire logic               i_inv_valid,
  input  wire logic               i_inv_has_asid,
  output logic                    o_inv_valid,
  output logic                    o_inv_scan_all,
  // control levels and the invalidate-everything pulse for the rest of the unit
  output logic                    o_ns_translation_enable,
  output logic                    o_s_translation_enable,
  output logic                    o_invalidate_everything,
  output logic [7:0]              o_walk_off,
  output logic                    o_context_tag_indexing
);
  logic [31:0]        wcc_q;
  logic               ns_en_q;
  logic               s_en_q;
  logic               tuning_q;
  logic               inv_pend_q;
  logic               inv_pulse_q;
  logic               ack_q;
  logic [31:0]        rdat_q;
  logic               req;
  logic               wr;
  logic               tuning_ok;
  logic               wcc_wr;
  logic [31:0]        wcc_d;
  logic [31:0]        rdat_d;
  logic [INDEX_W-1:0] index;
  logic [INDEX_W-1:0] index_no_asid;
  logic               lk_valid_q;
  logic [INDEX_W-1:0] lk_index_q;
  logic               lk_use_q;
  logic               inv_valid_q;
  logic               scan_all_q;

  // byte-lane merge of write data into a word; unselected lanes keep the old bytes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    return (old & ~{{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}})
           | (nw & {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}});
  endfunction

  // disable bit of a level: stage 1 levels sit at 8..11, stage 2 at 12..15
  function automatic logic level_off(input logic [31:0] ctl, input logic s2,
                                     input logic [LEVEL_W-1:0] lvl);
    return ctl[S1_LEVEL0_WALK_OFF_BIT + {29'h0, s2, lvl}]; // [R9] [R11]
  endfunction

  // bus decode; ack_q term makes each request answer exactly once
  assign req       = i_wb_cyc & i_wb_stb & ~ack_q;
  assign wr        = req & i_wb_we;
  assign tuning_ok = ~i_wb_tga_ns | tuning_q; // [R1]
  assign wcc_wr    = wr & (i_wb_adr[15:2] == WALK_CACHE_CONTROL_OFS[15:2])
                     & tuning_ok & ~ns_en_q & ~s_en_q; // [R1] [R2]
  assign wcc_d     = merge(wcc_q, i_wb_dat, i_wb_sel);

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_q <= 1'h0;
    end else begin
      ack_q <= req;
    end
  end

  // walk-cache control word; aux bits are stored as written, software keeps them zero
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wcc_q <= WALK_CACHE_CONTROL_RST; // [R12]
    end else if (wcc_wr) begin
      wcc_q <= wcc_d; // [R2]
    end
  end

  // translation enables and tuning grant; secure-only ones refuse non-secure writes
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ns_en_q  <= CONTROL_BIT_RST;
      s_en_q   <= CONTROL_BIT_RST;
      tuning_q <= CONTROL_BIT_RST;
    end else if (wr && i_wb_sel[0]) begin
      if (i_wb_adr[15:2] == NONSECURE_CONTROL_ZERO_OFS[15:2]) begin
        ns_en_q <= i_wb_dat[TRANSLATION_ENABLE_BIT];
      end
      if (!i_wb_tga_ns && i_wb_adr[15:2] == SECURE_CONTROL_ZERO_OFS[15:2]) begin
        s_en_q <= i_wb_dat[TRANSLATION_ENABLE_BIT];
      end
      if (!i_wb_tga_ns && i_wb_adr[15:2] == SECURE_SCOPE_CONTROL_OFS[15:2]) begin
        tuning_q <= i_wb_dat[NONSECURE_TUNING_ACCESS_BIT];
      end
    end
  end

  // invalidate-everything pulse and pending flag; a change wins over a same-cycle clear
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      inv_pulse_q <= 1'h0;
      inv_pend_q  <= 1'h0;
    end else begin
      inv_pulse_q <= wr && i_wb_sel[0] && !i_wb_tga_ns
                     && i_wb_adr[15:2] == SECURE_INITIALISATION_OFS[15:2]
                     && i_wb_dat[INVALIDATE_EVERYTHING_BIT]; // [R3]
      if (wcc_wr && wcc_d != wcc_q) begin
        inv_pend_q <= 1'h1; // [R3]
      end else if (inv_pulse_q) begin
        inv_pend_q <= 1'h0;
      end
    end
  end

  // read mux; unmapped or refused reads return zero
  always_comb begin
    rdat_d = 32'h0000_0000;
    if (i_wb_adr[15:2] == WALK_CACHE_CONTROL_OFS[15:2]) begin
      rdat_d = tuning_ok ? wcc_q : 32'h0000_0000; // [R1]
    end else if (i_wb_adr[15:2] == NONSECURE_CONTROL_ZERO_OFS[15:2]) begin
      rdat_d[TRANSLATION_ENABLE_BIT] = ns_en_q;
    end else if (!i_wb_tga_ns && i_wb_adr[15:2] == SECURE_CONTROL_ZERO_OFS[15:2]) begin
      rdat_d[TRANSLATION_ENABLE_BIT] = s_en_q;
    end else if (!i_wb_tga_ns && i_wb_adr[15:2] == SECURE_SCOPE_CONTROL_OFS[15:2]) begin
      rdat_d[NONSECURE_TUNING_ACCESS_BIT] = tuning_q;
    end else if (!i_wb_tga_ns && i_wb_adr[15:2] == SECURE_INITIALISATION_OFS[15:2]) begin
      rdat_d[INVALIDATE_PENDING_BIT] = inv_pend_q;
    end
  end

  // read data captured with the ack
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdat_q <= 32'h0000_0000;
    end else if (req && !i_wb_we) begin
      rdat_q <= rdat_d;
    end
  end

  walk_cache_index #(.INDEX_W(INDEX_W)) u_index (
    .i_vmid     (i_lk_vmid),
    .i_asid     (i_lk_asid),
    .i_addr     (i_lk_addr),
    .i_stage2   (i_lk_stage2),
    .i_level    (i_lk_level),
    .i_use_asid (wcc_q[CONTEXT_TAG_INDEXING_BIT]), // [R5] [R12]
    .o_index    (index)
  );

  // reference index with asid removed, read only by the checks below
  walk_cache_index #(.INDEX_W(INDEX_W)) u_index_ref (
    .i_vmid     (i_lk_vmid),
    .i_asid     ({ASID_W{1'b0}}),
    .i_addr     (i_lk_addr),
    .i_stage2   (i_lk_stage2),
    .i_level    (i_lk_level),
    .i_use_asid (1'b0),
    .o_index    (index_no_asid)
  );

  // lookup result: a disabled level is told not to hit or allocate
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lk_valid_q <= 1'h0;
      lk_index_q <= '0;
      lk_use_q   <= 1'h0;
    end else begin
      lk_valid_q <= i_lk_valid;
      if (i_lk_valid) begin
        lk_index_q <= index;
        lk_use_q   <= ~level_off(wcc_q, i_lk_stage2, i_lk_level); // [R7] [R8] [R10] [R13]
      end
    end
  end

  // invalidation without asid must scan everything under asid indexing
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      inv_valid_q <= 1'h0;
      scan_all_q  <= 1'h0;
    end else begin
      inv_valid_q <= i_inv_valid;
      scan_all_q  <= i_inv_valid & ~i_inv_has_asid
                     & wcc_q[CONTEXT_TAG_INDEXING_BIT]; // [R6]
    end
  end

  assign o_wb_ack                = ack_q;
  assign o_wb_dat                = rdat_q;
  assign o_lk_valid              = lk_valid_q;
  assign o_lk_index              = lk_index_q;
  assign o_lk_cache_use          = lk_use_q;
  assign o_inv_valid             = inv_valid_q;
  assign o_inv_scan_all          = scan_all_q;
  assign o_ns_translation_enable = ns_en_q;
  assign o_s_translation_enable  = s_en_q;
  assign o_invalidate_everything = inv_pulse_q;
  assign o_walk_off              = wcc_q[15:8]; // [R9]
  assign o_context_tag_indexing  = wcc_q[CONTEXT_TAG_INDEXING_BIT];

  // checks
  property p_ns_read_zero;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    (req && !i_wb_we && i_wb_tga_ns && !tuning_q
     && i_wb_adr[15:2] == WALK_CACHE_CONTROL_OFS[15:2]) |=> (o_wb_ack && o_wb_dat == 32'h0);
  endproperty
  a_ns_read_zero: assert property (p_ns_read_zero) else $error("ns read not zero"); // [R1]
  property p_ns_write_drop;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    (wr && i_wb_tga_ns && !tuning_q && i_wb_adr[15:2] == WALK_CACHE_CONTROL_OFS[15:2])
      |=> $stable(wcc_q);
  endproperty
  a_ns_write_drop: assert property (p_ns_write_drop) else $error("ns write taken"); // [R1]
  property p_write_blocked;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    (wr && (ns_en_q || s_en_q) && i_wb_adr[15:2] == WALK_CACHE_CONTROL_OFS[15:2])
      |=> $stable(wcc_q);
  endproperty
  a_write_blocked: assert property (p_write_blocked) else $error("write while enabled"); // [R2]
  property p_write_taken;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    (wr && !i_wb_tga_ns && !ns_en_q && !s_en_q && i_wb_sel == 4'hf
     && i_wb_adr[15:2] == WALK_CACHE_CONTROL_OFS[15:2]) |=> (wcc_q == $past(i_wb_dat));
  endproperty
  a_write_taken: assert property (p_write_taken) else $error("write lost"); // [R2]
  property p_same_index;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    (i_lk_valid && !wcc_q[CONTEXT_TAG_INDEXING_BIT]) |=> (o_lk_index == $past(index_no_asid));
  endproperty
  a_same_index: assert property (p_same_index) else $error("asid leaked into index"); // [R5]
  property p_scan_all;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    (i_inv_valid && !i_inv_has_asid && wcc_q[CONTEXT_TAG_INDEXING_BIT])
      |=> (o_inv_valid && o_inv_scan_all);
  endproperty
  a_scan_all: assert property (p_scan_all) else $error("no full scan"); // [R6]
  property p_s2l3_off;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    (i_lk_valid && i_lk_stage2 && i_lk_level == 2'h3 && wcc_q[S2_LEVEL3_WALK_OFF_BIT])
      |=> !o_lk_cache_use;
  endproperty
  a_s2l3_off: assert property (p_s2l3_off) else $error("s2 l3 cache used"); // [R7]
  property p_s2l2_on;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    (i_lk_valid && i_lk_stage2 && i_lk_level == 2'h2)
      |=> (o_lk_cache_use == !$past(wcc_q[S2_LEVEL2_WALK_OFF_BIT]));
  endproperty
  a_s2l2_on: assert property (p_s2l2_on) else $error("s2 l2 use wrong"); // [R8]
  property p_s1_off;
    @(posedge i_sys_clk) disable iff (!i_nrst)
    (i_lk_valid && !i_lk_stage2 && wcc_q[S1_LEVEL0_WALK_OFF_BIT + {30'h0, i_lk_level}])
      |=> (o_lk_valid && !o_lk_cache_use);
  endproperty
  a_s1_off: assert property (p_s1_off) else $error("s1 disabled level used"); // [R11]
endmodule

// >>> testbench/walk_cache_control_tb.sv
// self-checking bench for the walk-cache control register block
`timescale 1ns/1ps
module walk_cache_control_tb;
  import walk_cache_pkg::*;
  logic        i_sys_clk      = 1'b0;
  logic        i_nrst         = 1'b0;
  logic        i_wb_cyc       = 1'b0;
  logic        i_wb_stb       = 1'b0;
  logic        i_wb_we        = 1'b0;
  logic [15:0] i_wb_adr       = 16'h0000;
  logic [3:0]  i_wb_sel       = 4'h0;
  logic [31:0] i_wb_dat       = 32'h0000_0000;
  logic        i_wb_tga_ns    = 1'b0;
  logic        i_lk_valid     = 1'b0;
  logic        i_lk_stage2    = 1'b0;
  logic [1:0]  i_lk_level     = 2'h0;
  logic [15:0] i_lk_vmid      = 16'h1234;
  logic [15:0] i_lk_asid      = 16'h0000;
  logic [47:0] i_lk_addr      = 48'h0000_1234_5000;
  logic        i_inv_valid    = 1'b0;
  logic        i_inv_has_asid = 1'b0;
  logic [31:0] o_wb_dat;
  logic        o_wb_ack;
  logic        o_lk_valid;
  logic [7:0]  o_lk_index;
  logic        o_lk_cache_use;
  logic        o_inv_valid;
  logic        o_inv_scan_all;
  logic        o_ns_translation_enable;
  logic        o_s_translation_enable;
  logic        o_invalidate_everything;
  logic [7:0]  o_walk_off;
  logic        o_context_tag_indexing;
  int          fail_count = 0;
  int          n_compared = 0;
  logic [31:0] rd;
  logic [7:0]  idx_a;
  logic        inv_seen;
  logic [3:0]  sel_v = 4'hf;

  walk_cache_control dut_u (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .i_wb_tga_ns(i_wb_tga_ns), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_lk_valid(i_lk_valid), .i_lk_stage2(i_lk_stage2), .i_lk_level(i_lk_level),
    .i_lk_vmid(i_lk_vmid), .i_lk_asid(i_lk_asid), .i_lk_addr(i_lk_addr),
    .o_lk_valid(o_lk_valid), .o_lk_index(o_lk_index), .o_lk_cache_use(o_lk_cache_use),
    .i_inv_valid(i_inv_valid), .i_inv_has_asid(i_inv_has_asid),
    .o_inv_valid(o_inv_valid), .o_inv_scan_all(o_inv_scan_all),
    .o_ns_translation_enable(o_ns_translation_enable),
    .o_s_translation_enable(o_s_translation_enable),
    .o_invalidate_everything(o_invalidate_everything),
    .o_walk_off(o_walk_off), .o_context_tag_indexing(o_context_tag_indexing)
  );

  // 10 mhz system clock
  always #50 i_sys_clk = ~i_sys_clk;

  // verdict and end of run, shared by the main sequence and the watchdog
  task end_sim();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one classic wishbone cycle; inputs are sampled pre-update at each edge
  task wb_xfer(input logic w, input logic [15:0] adr, input logic [31:0] dat,
               input logic ns);
    int n;
    @(posedge i_sys_clk);
    i_wb_cyc    <= 1'b1;
    i_wb_stb    <= 1'b1;
    i_wb_we     <= w;
    i_wb_adr    <= adr;
    i_wb_dat    <= dat;
    i_wb_sel    <= sel_v;
    i_wb_tga_ns <= ns;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_wb_ack !== 1'b1);
    // ack one cycle after the take edge, so seen at the second edge
    chk(n, 32'd2, "ack latency");
    rd       = o_wb_dat;
    inv_seen = o_invalidate_everything;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we  <= 1'b0;
  endtask

  task wr(input logic [15:0] adr, input logic [31:0] dat, input logic ns);
    wb_xfer(1'b1, adr, dat, ns);
  endtask

  task rdc(input logic [15:0] adr, input logic ns, input logic [31:0] exp, input string what);
    wb_xfer(1'b0, adr, 32'h0, ns);
    chk(rd, exp, what);
  endtask

  // single lookup; results are looked at in the cycle after the take
  task lk(input logic s2, input logic [1:0] lv, input logic [15:0] asid);
    @(posedge i_sys_clk);
    i_lk_valid  <= 1'b1;
    i_lk_stage2 <= s2;
    i_lk_level  <= lv;
    i_lk_asid   <= asid;
    @(posedge i_sys_clk);
    i_lk_valid <= 1'b0;
    @(posedge i_sys_clk);
    chk(o_lk_valid, 32'h1, "lookup answer");
  endtask

  task inv(input logic has_asid, input logic exp);
    @(posedge i_sys_clk);
    i_inv_valid    <= 1'b1;
    i_inv_has_asid <= has_asid;
    @(posedge i_sys_clk);
    i_inv_valid <= 1'b0;
    @(posedge i_sys_clk);
    chk(o_inv_valid, 32'h1, "inv answer");
    chk(o_inv_scan_all, exp, "scan all");
  endtask

  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    #(5000 * 100);
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    @(posedge i_sys_clk);
    chk(o_context_tag_indexing, 32'h0, "indexing after reset");
    rdc(WALK_CACHE_CONTROL_OFS, 1'b0, WALK_CACHE_CONTROL_RST, "reset value");
    rdc(16'h8e40, 1'b0, 32'h0, "unmapped read");
    // each disable bit alone, against every stage and level
    for (int i = 0; i < 8; i++) begin
      wr(WALK_CACHE_CONTROL_OFS, 32'h1 << (8 + i), 1'b0);
      rdc(WALK_CACHE_CONTROL_OFS, 1'b0, 32'h1 << (8 + i), "readback");
      chk(o_walk_off, 32'h1 << i, "walk off");
      for (int j = 0; j < 8; j++) begin
        lk(j[2], j[1:0], 16'h0);
        chk(o_lk_cache_use, (i != j), "cache use");
      end
    end
    // indexing scheme, then asid-less invalidation cost
    wr(WALK_CACHE_CONTROL_OFS, 32'h0, 1'b0);
    lk(1'b0, 2'h1, 16'h0001);
    idx_a = o_lk_index;
    lk(1'b0, 2'h1, 16'h0002);
    chk(o_lk_index, idx_a, "same index across asid");
    inv(1'b0, 1'b0);
    wr(WALK_CACHE_CONTROL_OFS, 32'h1 << CONTEXT_TAG_INDEXING_BIT, 1'b0);
    chk(o_context_tag_indexing, 32'h1, "indexing bit");
    lk(1'b0, 2'h1, 16'h0001);
    idx_a = o_lk_index;
    lk(1'b0, 2'h1, 16'h0002);
    chk(o_lk_index !== idx_a, 32'h1, "distinct index per asid");
    inv(1'b0, 1'b1);
    inv(1'b1, 1'b0);
    // non-secure access without and with the tuning grant
    wr(WALK_CACHE_CONTROL_OFS, 32'h0000_0a00, 1'b0);
    rdc(WALK_CACHE_CONTROL_OFS, 1'b1, 32'h0, "ns read zero");
    wr(WALK_CACHE_CONTROL_OFS, 32'h0000_f000, 1'b1);
    rdc(WALK_CACHE_CONTROL_OFS, 1'b0, 32'h0000_0a00, "ns write dropped");
    wr(SECURE_SCOPE_CONTROL_OFS, 32'h1, 1'b0);
    wr(WALK_CACHE_CONTROL_OFS, 32'h0000_0500, 1'b1);
    rdc(WALK_CACHE_CONTROL_OFS, 1'b1, 32'h0000_0500, "ns granted");
    wr(SECURE_SCOPE_CONTROL_OFS, 32'h0, 1'b0);
    // writes refused while either translation enable is set
    wr(NONSECURE_CONTROL_ZERO_OFS, 32'h1, 1'b0);
    chk(o_ns_translation_enable, 32'h1, "ns enable");
    wr(WALK_CACHE_CONTROL_OFS, 32'h0000_0300, 1'b0);
    rdc(WALK_CACHE_CONTROL_OFS, 1'b0, 32'h0000_0500, "ns enable blocks");
    wr(NONSECURE_CONTROL_ZERO_OFS, 32'h0, 1'b0);
    wr(SECURE_CONTROL_ZERO_OFS, 32'h1, 1'b0);
    chk(o_s_translation_enable, 32'h1, "s enable");
    wr(WALK_CACHE_CONTROL_OFS, 32'h0000_0300, 1'b0);
    rdc(WALK_CACHE_CONTROL_OFS, 1'b0, 32'h0000_0500, "s enable blocks");
    wr(SECURE_CONTROL_ZERO_OFS, 32'h0, 1'b0);
    wr(WALK_CACHE_CONTROL_OFS, 32'h0000_0300, 1'b0);
    rdc(WALK_CACHE_CONTROL_OFS, 1'b0, 32'h0000_0300, "write accepted");
    // only the selected byte lane lands
    sel_v = 4'h2;
    wr(WALK_CACHE_CONTROL_OFS, 32'h0008_0c00, 1'b0);
    sel_v = 4'hf;
    rdc(WALK_CACHE_CONTROL_OFS, 1'b0, 32'h0000_0c00, "lane write");
    // software flushes before re-enabling translation
    rdc(SECURE_INITIALISATION_OFS, 1'b0, 32'h2, "flush pending");
    wr(SECURE_INITIALISATION_OFS, 32'h1, 1'b0);
    chk(inv_seen, 32'h1, "flush pulse");
    rdc(SECURE_INITIALISATION_OFS, 1'b0, 32'h0, "flush done");
    wr(NONSECURE_CONTROL_ZERO_OFS, 32'h1, 1'b0);
    chk(o_ns_translation_enable, 32'h1, "enable after flush");
    end_sim();
  end
endmodule
